// File: src/nrbwp_pkg.sv
// Package for the NAND ready/busy and write-protect host sequencer
// Assumes a 250 MHz controller clock and a device with an open-drain ready/busy line
package nrbwp_pkg;
    // ========================================
    // Commands
    localparam logic [7:0] NRBWP_CMD_STATUS = 8'h70;
    localparam logic [7:0] NRBWP_CMD_RESET = 8'hFF;
    // ========================================
    // Status byte layout
    localparam int NRBWP_STATUS_READY_BIT = 6;
    // ========================================
    // Timing
    localparam int NRBWP_CLK_MHZ = 250;
    localparam int NRBWP_T_SETTLE_NS = 100;
    localparam int NRBWP_SETTLE_CYC = (NRBWP_T_SETTLE_NS * NRBWP_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] NRBWP_SETTLE_LAST = 8'(NRBWP_SETTLE_CYC - 1);
    localparam logic [7:0] NRBWP_ZERO8 = 8'h00;
    localparam logic [7:0] NRBWP_ONE8 = 8'h01;
    // ========================================
    // Operation kinds
    typedef enum logic [1:0] {
        NRBWP_OP_READ = 2'b00,
        NRBWP_OP_PROGRAM = 2'b01,
        NRBWP_OP_ERASE = 2'b10,
        NRBWP_OP_OTHER = 2'b11
    } nrbwp_op_type;
    // ========================================
    // Sequencer states
    typedef enum logic [2:0] {
        NRBWP_ST_POWER = 3'b000,
        NRBWP_ST_INIT = 3'b001,
        NRBWP_ST_IDLE = 3'b010,
        NRBWP_ST_SETTLE = 3'b011,
        NRBWP_ST_BUSY = 3'b100,
        NRBWP_ST_DOWN = 3'b101
    } nrbwp_state_type;
endpackage

// File: src/nrbwp_host.sv
// Host-side sequencer: gates commands on ready/busy and drives write-protect
// Assumes the command engine issues a command only while cmd_ready is high and
// the ready/busy pin is pulled up externally and sampled on clk through a three-flop synchronizer here
`timescale 1ns/10ps
`default_nettype none
module nrbwp_host
    import nrbwp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic power_good,
    input wire logic rb_in,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [1:0] cmd_kind,
    output logic cmd_ready,
    input wire logic status_valid,
    input wire logic [7:0] status_byte,
    input wire logic wp_request,
    output logic wp_n,
    output logic dev_busy,
    output logic init_done
);
    // ========================================
    // Ready/busy synchronizer
    logic rb_s1_reg, rb_s2_reg, rb_s3_reg;
    logic rb_stable_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rb_s1_reg <= 1'b0;
            rb_s2_reg <= 1'b0;
            rb_s3_reg <= 1'b0;
        end else begin
            rb_s1_reg <= rb_in;
            rb_s2_reg <= rb_s1_reg;
            rb_s3_reg <= rb_s2_reg;
        end
    end
    // Level counts once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rb_stable_reg <= 1'b0;
        end else if (rb_s2_reg == rb_s3_reg) begin
            rb_stable_reg <= rb_s3_reg;
        end
    end
    // ========================================
    // Power-good synchronizer
    logic pg_s1_reg, pg_s2_reg, pg_s3_reg;
    logic pg_ok_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pg_s1_reg <= 1'b0;
            pg_s2_reg <= 1'b0;
            pg_s3_reg <= 1'b0;
        end else begin
            pg_s1_reg <= power_good;
            pg_s2_reg <= pg_s1_reg;
            pg_s3_reg <= pg_s2_reg;
        end
    end
    // Supply counts as valid or lost once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pg_ok_reg <= 1'b0;
        end else if (pg_s2_reg == pg_s3_reg) begin
            pg_ok_reg <= pg_s3_reg;
        end
    end
    // ========================================
    // Status poll result
    logic poll_ready;
    assign poll_ready = status_valid && status_byte[NRBWP_STATUS_READY_BIT];
    // ========================================
    // Sequencer
    nrbwp_state_type state_reg, state_next;
    nrbwp_op_type op_reg;
    logic [7:0] settle_reg;
    logic accept;
    logic dev_ready;
    logic is_status;
    assign is_status = (cmd_code == NRBWP_CMD_STATUS) || (cmd_code == NRBWP_CMD_RESET);
    assign dev_ready = rb_stable_reg || poll_ready;
    // Commands that need write-protect released before they are issued
    logic wp_needed;
    assign wp_needed = !is_status && (cmd_kind != NRBWP_OP_READ);
    always_comb begin
        cmd_ready = 1'b0;
        case (state_reg)
            NRBWP_ST_INIT: cmd_ready = (cmd_code == NRBWP_CMD_STATUS);
            NRBWP_ST_IDLE: cmd_ready = !wp_needed || wp_n;
            NRBWP_ST_SETTLE, NRBWP_ST_BUSY: cmd_ready = is_status;
            default: cmd_ready = 1'b0;
        endcase
    end
    assign accept = cmd_valid && cmd_ready;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NRBWP_ST_POWER: begin
                if (pg_ok_reg) begin
                    state_next = NRBWP_ST_INIT;
                end
            end
            NRBWP_ST_INIT: begin
                if (!pg_ok_reg) begin
                    state_next = NRBWP_ST_DOWN;
                end else if (dev_ready) begin
                    state_next = NRBWP_ST_IDLE;
                end
            end
            NRBWP_ST_IDLE: begin
                if (!pg_ok_reg) begin
                    state_next = NRBWP_ST_DOWN;
                end else if (accept && !is_status) begin
                    state_next = NRBWP_ST_SETTLE;
                end
            end
            NRBWP_ST_SETTLE: begin
                if (settle_reg == NRBWP_SETTLE_LAST) begin
                    state_next = NRBWP_ST_BUSY;
                end
            end
            NRBWP_ST_BUSY: begin
                if (dev_ready) begin
                    state_next = NRBWP_ST_IDLE;
                end
            end
            NRBWP_ST_DOWN: begin
                if (pg_ok_reg) begin
                    state_next = NRBWP_ST_INIT;
                end
            end
            default: state_next = NRBWP_ST_POWER;
        endcase
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= NRBWP_ST_POWER;
        end else begin
            state_reg <= state_next;
        end
    end
    // Gap lets the device pull the line low before the host looks at it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settle_reg <= NRBWP_ZERO8;
        end else if (state_reg == NRBWP_ST_SETTLE) begin
            settle_reg <= settle_reg + NRBWP_ONE8;
        end else begin
            settle_reg <= NRBWP_ZERO8;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_reg <= NRBWP_OP_OTHER;
        end else if (accept && !is_status && state_reg == NRBWP_ST_IDLE) begin
            op_reg <= nrbwp_op_type'(cmd_kind);
        end
    end
    // ========================================
    // Write protect
    logic wp_hold;
    logic powered;
    assign powered = (state_reg == NRBWP_ST_IDLE) || (state_reg == NRBWP_ST_SETTLE) || (state_reg == NRBWP_ST_BUSY);
    assign wp_hold = (state_reg == NRBWP_ST_SETTLE || state_reg == NRBWP_ST_BUSY)
                     && (op_reg == NRBWP_OP_PROGRAM || op_reg == NRBWP_OP_ERASE);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_n <= 1'b0;
        end else if (!powered || !pg_ok_reg) begin
            wp_n <= wp_hold;
        end else if (wp_hold || (cmd_valid && wp_needed && state_reg == NRBWP_ST_IDLE)) begin
            wp_n <= 1'b1;
        end else begin
            wp_n <= !wp_request;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dev_busy <= 1'b1;
            init_done <= 1'b0;
        end else begin
            dev_busy <= (state_next != NRBWP_ST_IDLE);
            init_done <= powered || (state_next == NRBWP_ST_IDLE);
        end
    end
    // ========================================
    // Assertions
    property p_init_gate;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_INIT && accept) |-> cmd_code == NRBWP_CMD_STATUS;
    endproperty
    a_init_gate: assert property (p_init_gate) else $error("non-status command during init");
    property p_wp_busy;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_BUSY && (op_reg == NRBWP_OP_PROGRAM || op_reg == NRBWP_OP_ERASE)) |-> wp_n;
    endproperty
    a_wp_busy: assert property (p_wp_busy) else $error("write protect during program or erase");
    property p_wp_prog;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_IDLE && accept && !is_status && cmd_kind == NRBWP_OP_PROGRAM) |-> wp_n [*3];
    endproperty
    a_wp_prog: assert property (p_wp_prog) else $error("write protect dropped after program");
    property p_wp_erase;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_IDLE && accept && !is_status && cmd_kind == NRBWP_OP_ERASE) |-> wp_n [*3];
    endproperty
    a_wp_erase: assert property (p_wp_erase) else $error("write protect dropped after erase");
    property p_wp_power;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_POWER) |=> !wp_n;
    endproperty
    a_wp_power: assert property (p_wp_power) else $error("write protect released without power");
    property p_busy_flag;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_IDLE && accept && !is_status) |=> dev_busy && !cmd_ready || is_status;
    endproperty
    a_busy_flag: assert property (p_busy_flag) else $error("not busy after accepted command");
    property p_release;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_BUSY && !rb_stable_reg && !poll_ready) |=> state_reg == NRBWP_ST_BUSY;
    endproperty
    a_release: assert property (p_release) else $error("left busy without ready");
    property p_settle;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_SETTLE && settle_reg == NRBWP_SETTLE_LAST) |=> state_reg == NRBWP_ST_BUSY;
    endproperty
    a_settle: assert property (p_settle) else $error("settle length wrong");
    property p_settle_hold;
        @(posedge clk) disable iff (!resetn)
        (state_reg == NRBWP_ST_SETTLE && settle_reg != NRBWP_SETTLE_LAST)
            |=> state_reg == NRBWP_ST_SETTLE && settle_reg == $past(settle_reg) + NRBWP_ONE8;
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("settle ended early");
    property p_sync;
        @(posedge clk) disable iff (!resetn)
        (rb_s2_reg == rb_s3_reg) |=> rb_stable_reg == $past(rb_s3_reg);
    endproperty
    a_sync: assert property (p_sync) else $error("ready level not followed");
    c_init: cover property (@(posedge clk) disable iff (!resetn) state_reg == NRBWP_ST_INIT ##[1:1000] state_reg == NRBWP_ST_IDLE);
    c_prog: cover property (@(posedge clk) disable iff (!resetn) op_reg == NRBWP_OP_PROGRAM && state_reg == NRBWP_ST_BUSY);
    c_erase: cover property (@(posedge clk) disable iff (!resetn) op_reg == NRBWP_OP_ERASE && state_reg == NRBWP_ST_BUSY);
    c_poll: cover property (@(posedge clk) disable iff (!resetn) state_reg == NRBWP_ST_BUSY && poll_ready);
endmodule // nrbwp_host
`default_nettype wire

// File: testbench/nrbwp_dev_model.sv
// NAND device model: init busy, operation busy, status byte
// Assumes the host changes its command inputs off the rising edge
`timescale 1ns/10ps
`default_nettype none
module nrbwp_dev_model
    import nrbwp_pkg::*;
#(
    parameter int INIT_CYC = 40,
    parameter int OP_CYC = 60
)
(
    input wire logic clk,
    input wire logic power_good,
    input wire logic cmd_take,
    input wire logic [7:0] cmd_code,
    input wire logic [1:0] cmd_kind,
    input wire logic wp_n,
    output logic rb_oe_n,
    output var logic status_valid,
    output var logic [7:0] status_byte,
    output var logic pe_busy
);
    int cnt = INIT_CYC;
    // ========================================
    // Busy timing
    always_ff @(posedge clk) begin
        if (!power_good) begin
            cnt <= INIT_CYC;
            pe_busy <= 1'b0;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end else if (cmd_take && cmd_code != NRBWP_CMD_STATUS && cmd_code != NRBWP_CMD_RESET
                     && cmd_kind != NRBWP_OP_OTHER) begin
            cnt <= OP_CYC;
            pe_busy <= cmd_kind != NRBWP_OP_READ && wp_n;
        end
    end
    // Only pulls low or floats
    assign rb_oe_n = (cnt == 0);
    // ========================================
    // Status read
    always_ff @(posedge clk) begin
        if (!power_good) begin
            status_valid <= 1'b0;
            status_byte <= 8'h00;
        end else begin
            status_valid <= cmd_take && cmd_code == NRBWP_CMD_STATUS;
            status_byte <= cmd_take ? {wp_n, cnt == 0, 6'h00} : ~status_byte;
        end
    end
endmodule // nrbwp_dev_model
`default_nettype wire

// File: testbench/test_nand_ready_busy_write_protect.sv
// Bench for the NAND ready/busy and write-protect host sequencer
// Assumes the device model nrbwp_dev_model and a pulled-up ready/busy line
`timescale 1ns/10ps
`default_nettype none
module test_nand_ready_busy_write_protect;
    import nrbwp_pkg::*;
    localparam int INIT_CYC = 40;
    localparam int OP_CYC = 60;
    typedef struct {logic [7:0] code; logic [1:0] kind; logic pe; int min;} nrbwp_row_type;
    nrbwp_row_type rows [4] = '{'{8'h00, 2'h0, 1'b0, OP_CYC}, '{8'h80, 2'h1, 1'b1, OP_CYC},
        '{8'h60, 2'h2, 1'b1, OP_CYC}, '{8'h90, 2'h3, 1'b0, NRBWP_SETTLE_CYC}};
    logic clk = 1'b0, resetn = 1'b0, power_good = 1'b0, cmd_valid = 1'b0, wp_request = 1'b0;
    logic other_n = 1'b1;
    logic [7:0] cmd_code = 8'h00, status_byte;
    logic [1:0] cmd_kind = 2'h0;
    logic rb_in, rb_oe_n, cmd_ready, status_valid, wp_n, dev_busy, init_done, pe_busy;
    int num_errors = 0, num_checks = 0, n;
    // Second open-drain puller shares the line
    assign rb_in = rb_oe_n & other_n;
    initial forever #2 clk = ~clk;
    nrbwp_host DUT (.clk(clk), .resetn(resetn), .power_good(power_good), .rb_in(rb_in),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_kind(cmd_kind), .cmd_ready(cmd_ready),
        .status_valid(status_valid), .status_byte(status_byte), .wp_request(wp_request),
        .wp_n(wp_n), .dev_busy(dev_busy), .init_done(init_done));
    nrbwp_dev_model #(.INIT_CYC(INIT_CYC), .OP_CYC(OP_CYC)) model (.clk(clk),
        .power_good(power_good), .cmd_take(cmd_valid && cmd_ready), .cmd_code(cmd_code),
        .cmd_kind(cmd_kind), .wp_n(wp_n), .rb_oe_n(rb_oe_n), .status_valid(status_valid),
        .status_byte(status_byte), .pe_busy(pe_busy));
    // ========================================
    // Tasks
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic send(input logic [7:0] code, input logic [1:0] kind);
        int c;
        c = 0;
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_kind = kind;
        while (cmd_ready !== 1'b1 && c < 500) begin
            @(negedge clk);
            c++;
        end
        chk("cmd_ready", 8'h01, cmd_ready);
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    task automatic wait_idle(output int c);
        c = 0;
        while (dev_busy !== 1'b0 && c < 1000) begin
            @(negedge clk);
            c++;
        end
        chk("dev_busy", 8'h00, dev_busy);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ========================================
    // Monitors
    always @(negedge clk) begin
        if (power_good && init_done === 1'b1 && rb_oe_n === 1'b0) chk("dev_busy", 8'h01, dev_busy);
        if (pe_busy === 1'b1 && rb_oe_n === 1'b0) chk("wp_n", 8'h01, wp_n);
    end
    initial begin
        #20000;
        num_errors++;
        end_sim;
    end
    // ========================================
    // Tests
    initial begin
        repeat (16) @(negedge clk);
        chk("dev_busy", 8'h01, dev_busy);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        chk("wp_n", 8'h00, wp_n);
        $display("test reset done");
        power_good = 1'b1;
        repeat (4) @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = 8'h80;
        cmd_kind = 2'h1;
        @(negedge clk);
        chk("cmd_ready", 8'h00, cmd_ready);
        send(NRBWP_CMD_STATUS, 2'h3);
        repeat (INIT_CYC - 12) @(negedge clk);
        chk("init_done", 8'h00, init_done);
        for (n = 0; init_done !== 1'b1 && n < 100; n++) @(negedge clk);
        chk("init_done", 8'h01, init_done);
        $display("test init done");
        foreach (rows[i]) begin
            send(rows[i].code, rows[i].kind);
            chk("dev_busy", 8'h01, dev_busy);
            if (rows[i].pe) chk("wp_n", 8'h01, wp_n);
            if (rows[i].pe) chk("pe_busy", 8'h01, pe_busy);
            wait_idle(n);
            chk("busy_len", 8'h01, 8'(n >= rows[i].min - 2 && n < 1000));
            $display("test row %0d done", i);
        end
        send(8'h80, 2'h1);
        repeat (30) @(negedge clk);
        wp_request = 1'b1;
        repeat (8) @(negedge clk);
        chk("wp_n", 8'h01, wp_n);
        wait_idle(n);
        repeat (3) @(negedge clk);
        chk("wp_n", 8'h00, wp_n);
        wp_request = 1'b0;
        $display("test protect done");
        send(8'h60, 2'h2);
        chk("pe_busy", 8'h01, pe_busy);
        other_n = 1'b0;
        repeat (OP_CYC + 4) @(negedge clk);
        chk("dev_busy", 8'h01, dev_busy);
        send(NRBWP_CMD_STATUS, 2'h3);
        repeat (3) @(negedge clk);
        chk("dev_busy", 8'h00, dev_busy);
        other_n = 1'b1;
        $display("test poll done");
        power_good = 1'b0;
        repeat (8) @(negedge clk);
        chk("wp_n", 8'h00, wp_n);
        chk("init_done", 8'h00, init_done);
        $display("test power off done");
        end_sim;
    end
endmodule // test_nand_ready_busy_write_protect
`default_nettype wire
